/* dv/serial_clock_sink.sv */
/*
  Serial port stand-in: counts the receive and transmit clock pulses.
  Assumes one-cycle pulses on pclk; clear zeroes both counts.
*/
`timescale 1ns/1ps
module serial_clock_sink
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        rx_clock_pulse,
  input  wire        tx_clock_pulse,
  input  wire        clear,
  output reg  [15:0] rx_count,
  output reg  [15:0] tx_count
);
  // Each pulse is one bit-clock tick for the serial side
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn || clear)
    begin
      rx_count <= 16'h0000;
      tx_count <= 16'h0000;
    end
    else
    begin
      rx_count <= rx_count + {15'h0000, rx_clock_pulse};
      tx_count <= tx_count + {15'h0000, tx_clock_pulse};
    end
  end
endmodule // serial_clock_sink

/* dv/tb_top.sv */
/*
  Self-checking bench for timer_two: APB tasks and directed tests.
  Assumes the constants header on the include path and the bound checker.
*/
`timescale 1ns/1ps
`include "timer_two_consts.vh"
module tb_top;
  localparam [9:0] CTL = `IDX_TIMER_TWO_CONTROL;
  localparam [9:0] MD  = `IDX_TIMER_TWO_MODE;
  localparam [9:0] RLL = `IDX_RELOAD_LOW;
  localparam [9:0] RLH = `IDX_RELOAD_HIGH;
  localparam [9:0] CNL = `IDX_COUNT_LOW;
  localparam [9:0] CNH = `IDX_COUNT_HIGH;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg         trig = 1'b1;       // Pins idle high
  reg         ev = 1'b1;
  reg         clr = 1'b0;
  reg  [32:0] rdv;               // Error bit and read data of last transfer
  reg  [32:0] keep;
  integer     errors = 0;
  integer     total_checks = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, clock_out, clock_out_oe, rxp, txp, irq;
  wire [15:0] rx_n, tx_n;

  always #5 pclk = ~pclk;

  timer_two DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_trigger_pin(trig),
    .event_in(ev), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .rx_clock_pulse(rxp), .tx_clock_pulse(txp), .timer_irq_request(irq));
  serial_clock_sink u_sink (.pclk(pclk), .presetn(presetn), .rx_clock_pulse(rxp),
    .tx_clock_pulse(txp), .clear(clr), .rx_count(rx_n), .tx_count(tx_n));

  // One APB transfer; request held until ready is sampled high
  task apb(input w, input [9:0] i, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // No assumed wait count; only the watchdog ends a hang
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rdv = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Value compare and range compare
  task chk(input [32:0] got, input [32:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task chk_range(input [15:0] got, input [15:0] lo, input [15:0] hi);
    chk({17'h00000, got >= lo && got <= hi}, 33'h000000001);
  endtask
  task wr(input [9:0] i, input [7:0] d); apb(1'b1, i, d); endtask
  task rd(input [9:0] i, input [7:0] e);
    begin
      apb(1'b0, i, 8'h00);
      chk(rdv, {25'h0000000, e});
    end
  endtask
  // Falling edge on one pin, held long enough for the synchroniser
  task pin_pulse(input sel);
    begin
      @(posedge pclk);
      if (sel) ev <= 1'b0; else trig <= 1'b0;
      repeat (4) @(posedge pclk);
      if (sel) ev <= 1'b1; else trig <= 1'b1;
      repeat (6) @(posedge pclk);
    end
  endtask
  task clear_sink;
    begin
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // Watchdog well beyond the roughly 1000 cycles the tests need
  initial
  begin
    #400000;
    errors = errors + 1;
    tally_and_finish;
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, mode bits, unmapped index
    rd(CTL, 8'h00);
    rd(MD, 8'h00);
    wr(MD, 8'h03); rd(MD, 8'h03);
    wr(MD, 8'h00);
    apb(1'b0, 10'h0CE, 8'h00); chk(rdv, {1'b1, 32'h00000000});
    $display("test registers finished");
    // Up count to overflow and reload, then stop
    wr(RLL, 8'h34); wr(RLH, 8'h12); wr(CNL, 8'hFE); wr(CNH, 8'hFF);
    wr(CTL, 8'h04); repeat (50) @(posedge pclk);
    rd(CTL, 8'h84); chk({32'h0, irq}, 33'h1);
    rd(CNH, 8'h12);
    wr(CTL, 8'h00); rd(CTL, 8'h00); chk({32'h0, irq}, 33'h0);
    apb(1'b0, CNL, 8'h00); keep = rdv; repeat (30) @(posedge pclk);
    apb(1'b0, CNL, 8'h00); chk(rdv, keep);
    $display("test up count finished");
    // Event counting only while running
    wr(CNL, 8'h00); wr(CNH, 8'h00); wr(CTL, 8'h02);
    pin_pulse(1'b1); pin_pulse(1'b1); rd(CNL, 8'h00);
    wr(CTL, 8'h06);
    repeat (3) pin_pulse(1'b1);
    rd(CNL, 8'h03);
    $display("test events finished");
    // Trigger reload, ignored trigger, capture
    wr(RLL, 8'h55); wr(RLH, 8'h44); wr(CTL, 8'h0E); pin_pulse(1'b0);
    rd(CTL, 8'h4E); chk({32'h0, irq}, 33'h1);
    rd(CNL, 8'h55); rd(CNH, 8'h44);
    wr(CTL, 8'h06); pin_pulse(1'b0);
    rd(CTL, 8'h06); chk({32'h0, irq}, 33'h0);
    wr(CNL, 8'h11); wr(CNH, 8'h22); wr(CTL, 8'h0F); pin_pulse(1'b0);
    rd(RLL, 8'h11); rd(RLH, 8'h22); rd(CTL, 8'h4F);
    $display("test trigger finished");
    // Up/down: down to the reload value, then up past the top
    wr(CTL, 8'h00); wr(MD, 8'h01); trig <= 1'b0;
    wr(RLL, 8'h00); wr(RLH, 8'h01); wr(CNL, 8'h01); wr(CNH, 8'h01);
    wr(CTL, 8'h04); repeat (50) @(posedge pclk);
    rd(CNH, 8'hFF); rd(CTL, 8'hC4);
    wr(CTL, 8'h44); rd(CTL, 8'h44); chk({32'h0, irq}, 33'h0);
    wr(CTL, 8'h00); trig <= 1'b1; wr(CNL, 8'hFE); wr(CNH, 8'hFF);
    wr(CTL, 8'h04); repeat (50) @(posedge pclk);
    rd(CNH, 8'h01); rd(CTL, 8'hC4);
    wr(CTL, 8'h00); wr(MD, 8'h00);
    $display("test up down finished");
    // Serial clock: state-time rate, no overflow flag, edge sets flag only
    wr(RLL, 8'hF0); wr(RLH, 8'hFF); wr(CNL, 8'hF0); wr(CNH, 8'hFF);
    wr(CTL, 8'h3C); clear_sink; repeat (320) @(posedge pclk);
    chk_range(rx_n, 16'h0009, 16'h000B);
    chk_range(tx_n, 16'h0009, 16'h000B);
    rd(CTL, 8'h3C);
    pin_pulse(1'b0); rd(CTL, 8'h7C);
    wr(CTL, 8'h24); clear_sink; repeat (100) @(posedge pclk);
    chk({17'h0, tx_n}, 33'h0);
    chk_range(rx_n, 16'h0002, 16'h0004);
    // Clock out: wraps come every 32 cycles, so one toggle per window
    wr(MD, 8'h02); repeat (40) @(posedge pclk);
    keep = {32'h0, clock_out}; repeat (32) @(posedge pclk);
    chk({32'h0, clock_out}, {32'h0, ~keep[0]});
    chk({32'h0, clock_out_oe}, 33'h1);
    wr(MD, 8'h00); repeat (2) @(posedge pclk);
    chk({31'h0, clock_out_oe, clock_out}, 33'h0);
    $display("test serial finished");
    tally_and_finish;
  end
endmodule // tb_top

/* dv/timer_two_monitor.sv */
/*
  Port checker for timer_two: bus answers, clock pulses, mode enable.
  Assumes the constants header is on the include path; bound below.
*/
`timescale 1ns/1ps
`include "timer_two_consts.vh"
module timer_two_monitor
(
  input wire               pclk,
  input wire               presetn,
  input wire               psel,
  input wire               penable,
  input wire               pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0]        pwdata,
  input wire [31:0]        prdata,
  input wire               pready,
  input wire               pslverr,
  input wire               external_trigger_pin,
  input wire               event_in,
  input wire               clock_out,
  input wire               clock_out_oe,
  input wire               rx_clock_pulse,
  input wire               tx_clock_pulse,
  input wire               timer_irq_request
);
  wire mapped; // Index falls on one of the six registers
  assign mapped = paddr[`IDX_MSB:`IDX_LSB] >= `IDX_TIMER_TWO_CONTROL
                  && paddr[`IDX_MSB:`IDX_LSB] <= `IDX_COUNT_HIGH;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle, and the access edge of a mode write
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_mode_wr;
    psel && penable && pready && pwrite
      && paddr[`IDX_MSB:`IDX_LSB] == `IDX_TIMER_TWO_MODE;
  endsequence
  property p_ready_after_setup; s_setup |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_err_unmapped; s_setup ##0 !mapped |=> pslverr; endproperty
  property p_ok_mapped; s_setup ##0 mapped |=> !pslverr; endproperty
  property p_rdata_idle; !pready |-> prdata == `RDATA_IDLE; endproperty
  property p_rx_one; rx_clock_pulse |=> !rx_clock_pulse; endproperty
  property p_tx_one; tx_clock_pulse |=> !tx_clock_pulse; endproperty
  property p_oe_on; s_mode_wr ##0 pwdata[1] |-> ##2 clock_out_oe; endproperty
  property p_oe_off; s_mode_wr ##0 !pwdata[1] |-> ##2 !clock_out_oe; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  a_ready_one: assert property (p_ready_one)
    else $error("ready wider than one cycle");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access without error");
  a_ok_mapped: assert property (p_ok_mapped)
    else $error("mapped access with error");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside access");
  a_rx_one: assert property (p_rx_one)
    else $error("receive pulse too wide");
  a_tx_one: assert property (p_tx_one)
    else $error("transmit pulse too wide");
  a_oe_on: assert property (p_oe_on)
    else $error("output enable not raised");
  a_oe_off: assert property (p_oe_off)
    else $error("output enable not dropped");
endmodule // timer_two_monitor

bind timer_two timer_two_monitor u_mon
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .external_trigger_pin(external_trigger_pin), .event_in(event_in),
  .clock_out(clock_out), .clock_out_oe(clock_out_oe),
  .rx_clock_pulse(rx_clock_pulse), .tx_clock_pulse(tx_clock_pulse),
  .timer_irq_request(timer_irq_request)
);

/* rtl/edge_sync.v */
/*
  Two-stage synchroniser for one pin with a falling-edge pulse.
  Assumes the pin idles high and is asynchronous to pclk.
*/
`timescale 1ns/1ps
module edge_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire pin,
  output reg  level,
  output reg  fall
);
  reg meta;                             // First stage, read by level only
  reg last;                             // Previous settled sample

  // Two flops before any logic, then compare successive samples
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      last  <= 1'b1;
      fall  <= 1'b0;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
      last  <= level;
      fall  <= last & ~level;
    end
  end
endmodule // edge_sync

/* rtl/tick_divider.v */
/*
  Divides pclk into one-cycle enables: a state-time tick every second
  cycle and a machine-cycle tick every twelfth cycle.
  Assumes pclk stands in for the crystal clock.
*/
`timescale 1ns/1ps
`include "timer_two_consts.vh"
module tick_divider
(
  input  wire pclk,
  input  wire presetn,
  output reg  state_tick,
  output reg  machine_tick
);
  reg [3:0] phase;                      // Position within the machine cycle

  // Free-running modulo-twelve phase; odd phases mark state times
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase        <= 4'h0;
      state_tick   <= 1'b0;
      machine_tick <= 1'b0;
    end
    else
    begin
      phase        <= (phase == `TICK_LAST) ? 4'h0 : phase + 4'h1;
      state_tick   <= phase[0];
      machine_tick <= (phase == `TICK_LAST);
    end
  end
endmodule // tick_divider

/* rtl/timer_two.v */
/*
  16-bit timer/counter with capture, auto-reload (up or down) and
  serial clock generation, reached over APB.
  Assumes an APB3 master on pclk, a trigger pin and an event pin both
  asynchronous to pclk, and a serial port that takes the clock pulses.
*/
// What this block does
// - Overflow sets sticky flag, not in serial mode
// - Trigger capture or reload sets external flag
// - External flag raises no request when updown
// - Receive select routes overflow pulses to receiver
// - Transmit select routes overflow pulses to transmitter
// - Edge enable gates trigger pin falling edges
// - Run bit starts and stops counting
// - Source: machine-cycle ticks or event pin edges
// - Capture bit picks capture or reload on edge
// - Serial mode forces auto-reload on overflow
// - Mode register: clock out and updown enables
// - Updown enable resets to zero, count up
// - Up count overflows past FFFF, reloads (wraps to zero in capture mode)
// - Edge enable: edge also reloads, sets flag
// - Request while overflow flag is set, or external flag when updown is off
// - Updown, pin high: count up, reload on overflow
// - Updown, pin low: count down, underflow to FFFF
// - Updown: external flag toggles each wrap
// - Serial mode: edge sets flag, no reload
// - Serial internal source ticks every state time
`timescale 1ns/1ps
`include "timer_two_consts.vh"
module timer_two
(
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire                 external_trigger_pin,
  input  wire                 event_in,
  output reg                  clock_out,
  output reg                  clock_out_oe,
  output reg                  rx_clock_pulse,
  output reg                  tx_clock_pulse,
  output reg                  timer_irq_request
);

  // Register state
  reg [7:0]  control;                   // Control register image
  reg [1:0]  mode;                      // Clock out and updown enables
  reg [15:0] count;                     // Counter high and low bytes
  reg [15:0] reload;                    // Reload / capture pair

  // Next values
  reg [7:0]  next_control;
  reg [15:0] next_count;
  reg [15:0] next_reload;
  reg        wrap;                      // Overflow or underflow this cycle

  // Synchronised pins and tick enables
  wire trig_level;                      // Settled trigger level
  wire trig_fall;                       // Trigger falling edge pulse
  wire event_fall;                      // Event falling edge pulse
  wire state_tick;                      // Every second pclk
  wire machine_tick;                    // Every twelfth pclk

  // Decoded bus access
  wire [9:0] idx;
  wire       setup_phase;
  wire       write_now;

  // Decoded modes
  wire run;
  wire serial_mode;
  wire updown;
  wire capture_mode;
  wire edge_hit;
  wire count_tick;

  // Returns 1 when a register index is mapped
  function mapped;
    input [9:0] i;
    begin
      mapped = (i == `IDX_TIMER_TWO_CONTROL) || (i == `IDX_TIMER_TWO_MODE) ||
               (i == `IDX_RELOAD_LOW) || (i == `IDX_RELOAD_HIGH) ||
               (i == `IDX_COUNT_LOW) || (i == `IDX_COUNT_HIGH);
    end
  endfunction

  // Read mux; unmapped and reserved bits read as zero
  function [31:0] read_word;
    input [9:0]  i;
    input [7:0]  c;
    input [1:0]  m;
    input [15:0] cnt;
    input [15:0] rl;
    begin
      case (i)
        `IDX_TIMER_TWO_CONTROL: read_word = {`BYTE_PAD, c};
        `IDX_TIMER_TWO_MODE:    read_word = {`MODE_PAD, m};
        `IDX_RELOAD_LOW:        read_word = {`BYTE_PAD, rl[`BYTE_MSB:`BYTE_LSB]};
        `IDX_RELOAD_HIGH:       read_word = {`BYTE_PAD, rl[`HIGH_MSB:`HIGH_LSB]};
        `IDX_COUNT_LOW:         read_word = {`BYTE_PAD, cnt[`BYTE_MSB:`BYTE_LSB]};
        `IDX_COUNT_HIGH:        read_word = {`BYTE_PAD, cnt[`HIGH_MSB:`HIGH_LSB]};
        default:                read_word = `RDATA_IDLE;
      endcase
    end
  endfunction

  // Trigger pin synchroniser
  edge_sync u_trig_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (external_trigger_pin),
    .level   (trig_level),
    .fall    (trig_fall)
  );

  // Event pin synchroniser
  edge_sync u_event_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (event_in),
    .level   (),
    .fall    (event_fall)
  );

  // Machine-cycle and state-time enables
  tick_divider u_ticks
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .state_tick   (state_tick),
    .machine_tick (machine_tick)
  );

  assign idx         = paddr[`IDX_MSB:`IDX_LSB];
  assign setup_phase = psel & ~penable & ~pready;
  assign write_now   = psel & penable & pready & pwrite & ~pslverr;

  assign run          = control[`CTL_RUN];
  assign serial_mode  = control[`CTL_RX_CLK] | control[`CTL_TX_CLK];
  // Serial mode ignores the capture bit and the direction pin
  assign capture_mode = control[`CTL_CAPTURE] & ~serial_mode;
  assign updown       = mode[`MODE_UPDOWN] & ~serial_mode & ~capture_mode;
  // Edges only count while enabled and running; the pin level still sets updown direction
  assign edge_hit     = run & control[`CTL_EXT_EN] & trig_fall;

  // Internal source: state time in serial mode, else machine cycle
  assign count_tick = run & (control[`CTL_SRC] ? event_fall :
                             (serial_mode ? state_tick : machine_tick));

  // APB answer: zero wait states, registered read data and error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RDATA_IDLE;
    end
    else if (setup_phase)
    begin
      // Sample in setup, answer in the first access cycle
      pready  <= 1'b1;
      pslverr <= ~mapped(idx);
      prdata  <= pwrite ? `RDATA_IDLE : read_word(idx, control, mode, count, reload);
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RDATA_IDLE;
    end
  end

  // Counting, reload, capture and flag updates
  always @*
  begin
    next_control = control;
    next_count   = count;
    next_reload  = reload;
    wrap         = 1'b0;

    // Software writes first; hardware events below win over a clear
    if (write_now && idx == `IDX_TIMER_TWO_CONTROL)
    begin
      next_control = pwdata[`BYTE_MSB:`BYTE_LSB];
    end
    if (write_now && idx == `IDX_RELOAD_LOW)
    begin
      next_reload[`BYTE_MSB:`BYTE_LSB] = pwdata[`BYTE_MSB:`BYTE_LSB];
    end
    if (write_now && idx == `IDX_RELOAD_HIGH)
    begin
      next_reload[`HIGH_MSB:`HIGH_LSB] = pwdata[`BYTE_MSB:`BYTE_LSB];
    end

    if (count_tick)
    begin
      if (serial_mode)
      begin
        // Baud generation: reload on rollover, overflow flag untouched
        if (count == `COUNT_MAX)
        begin
          next_count = reload;
          wrap       = 1'b1;
        end
        else
        begin
          next_count = count + `COUNT_ONE;
        end
      end
      else if (updown && trig_level)
      begin
        // Direction pin high: count up
        if (count == `COUNT_MAX)
        begin
          next_count = reload;
          next_control[`CTL_OVERFLOW] = 1'b1;
          next_control[`CTL_EXT_FLAG] = ~next_control[`CTL_EXT_FLAG];
          wrap = 1'b1;
        end
        else
        begin
          next_count = count + `COUNT_ONE;
        end
      end
      else if (updown)
      begin
        // Direction pin low: count down to the reload value
        if (count == reload)
        begin
          next_count = `COUNT_MAX;
          next_control[`CTL_OVERFLOW] = 1'b1;
          next_control[`CTL_EXT_FLAG] = ~next_control[`CTL_EXT_FLAG];
          wrap = 1'b1;
        end
        else
        begin
          next_count = count - `COUNT_ONE;
        end
      end
      else
      begin
        // Up count; capture mode wraps to zero, reload mode reloads
        if (count == `COUNT_MAX)
        begin
          next_count = capture_mode ? `COUNT_RESET : reload;
          next_control[`CTL_OVERFLOW] = 1'b1;
          wrap = 1'b1;
        end
        else
        begin
          next_count = count + `COUNT_ONE;
        end
      end
    end

    // Trigger edge; in updown mode the pin only sets direction
    if (edge_hit && !updown)
    begin
      next_control[`CTL_EXT_FLAG] = 1'b1;
      if (serial_mode)
      begin
        // Spare interrupt source only, counter left alone
        next_count = next_count;
      end
      else if (capture_mode)
      begin
        next_reload = count;
      end
      else
      begin
        next_count = reload;
      end
    end

    // A write to the count bytes overrides the counter this cycle
    if (write_now && idx == `IDX_COUNT_LOW)
    begin
      next_count[`BYTE_MSB:`BYTE_LSB] = pwdata[`BYTE_MSB:`BYTE_LSB];
    end
    if (write_now && idx == `IDX_COUNT_HIGH)
    begin
      next_count[`HIGH_MSB:`HIGH_LSB] = pwdata[`BYTE_MSB:`BYTE_LSB];
    end
  end

  // Register state update
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control <= `CONTROL_RESET;
      mode    <= `MODE_RESET;
      count   <= `COUNT_RESET;
      reload  <= `RELOAD_RESET;
    end
    else
    begin
      control <= next_control;
      count   <= next_count;
      reload  <= next_reload;
      if (write_now && idx == `IDX_TIMER_TWO_MODE)
      begin
        // Only the two implemented bits are stored
        mode <= pwdata[`MODE_CLK_OE:`MODE_UPDOWN];
      end
    end
  end

  // Serial clock pulses; a pulse lasts one pclk per wrap
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_clock_pulse <= 1'b0;
      tx_clock_pulse <= 1'b0;
    end
    else
    begin
      rx_clock_pulse <= wrap & control[`CTL_RX_CLK];
      tx_clock_pulse <= wrap & control[`CTL_TX_CLK];
    end
  end

  // Clock out: toggles on every wrap while enabled, drives the event pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_out    <= 1'b0;
      clock_out_oe <= 1'b0;
    end
    else
    begin
      clock_out_oe <= mode[`MODE_CLK_OE];
      if (!mode[`MODE_CLK_OE])
      begin
        clock_out <= 1'b0;
      end
      else if (wrap)
      begin
        clock_out <= ~clock_out;
      end
    end
  end

  // Request level follows the next flags so it tracks them exactly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_irq_request <= 1'b0;
    end
    else
    begin
      timer_irq_request <= next_control[`CTL_OVERFLOW] |
                           (next_control[`CTL_EXT_FLAG] & ~mode[`MODE_UPDOWN]);
    end
  end

endmodule // timer_two

/* rtl/timer_two_consts.vh */
/*
  Constants for the 16-bit reload timer: register indices, control and
  mode field positions, reset values, tick dividers and bus answers.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef TIMER_TWO_CONSTS_VH
`define TIMER_TWO_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_TIMER_TWO_CONTROL 10'h0C8
`define IDX_TIMER_TWO_MODE    10'h0C9
`define IDX_RELOAD_LOW        10'h0CA
`define IDX_RELOAD_HIGH       10'h0CB
`define IDX_COUNT_LOW         10'h0CC
`define IDX_COUNT_HIGH        10'h0CD

// Bus geometry
`define ADDR_W     12
`define IDX_LSB    2
`define IDX_MSB    11
`define BYTE_LSB   0
`define BYTE_MSB   7
`define HIGH_LSB   8
`define HIGH_MSB   15

// Control register fields
`define CTL_OVERFLOW   7
`define CTL_EXT_FLAG   6
`define CTL_RX_CLK     5
`define CTL_TX_CLK     4
`define CTL_EXT_EN     3
`define CTL_RUN        2
`define CTL_SRC        1
`define CTL_CAPTURE    0

// Mode register fields
`define MODE_CLK_OE    1
`define MODE_UPDOWN    0

// Reset values
`define CONTROL_RESET  8'h00
`define MODE_RESET     2'h0
`define COUNT_RESET    16'h0000
`define RELOAD_RESET   16'h0000
`define COUNT_MAX      16'hFFFF
`define COUNT_ONE      16'h0001

// Tick rates: state time is half the clock, machine cycle a twelfth
`define TICK_DIV_MACHINE 4'hC
`define TICK_DIV_STATE   4'h2
`define TICK_LAST        4'hB

// Bus answers
`define RDATA_IDLE     32'h00000000
`define BYTE_PAD       24'h000000
`define MODE_PAD       30'h00000000

`endif
